// *** design/als_top.sv ***
// Functional notes
// - normal: input/output lamps on, alarms released, module_present low
// - thermal warning: service lamp, otw low; shutdown adds fault, pg low
// - fuse/boost/overvoltage: input lamp on, fault lamp, fault and pg low
// - input out of limits: blink input lamp, pg low, fault high
// - input absent: all lamps dark, pg low (valid when back-biased)
// - overcurrent: blink output lamp, fault high, pg pulses at 1 ms
// - internal non-shutdown fault: fault lamp, fault low, pg high
// - output on only when on/off tied to logic_ground; standby pg low (the code drives pg low for standby in pmbus mode only)
// - service request in pmbus mode blinks service lamp, alarms high
// - rs485 comm fault blinks fault lamp, alarms high
// - alarm outputs open drain active low, external pull-ups
// - pg low whenever loss of main output may be imminent
// - protocol pin open selects pmbus, tied low selects rs485
// - address bits a3..a0 from unit strap then rack strap
// - main output disabled unless slot strap is present
// - main output gated by the short interlock pin
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "als_consts.svh"

module als_top #(
  parameter int BLINK_CYC = `ALS_BLINK_CYC,
  parameter int PG_CYC    = `ALS_PG_CYC,
  parameter int STRAP_W   = 2
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // avalon-mm slave
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output      logic [31:0]             avs_readdata,
  output      logic                    avs_waitrequest,
  output      logic                    irq,
  // internal conditions from the power stages
  input  wire logic                    thermal_warn,
  input  wire logic                    thermal_shutdown,
  input  wire logic                    input_fuse_blown,
  input  wire logic                    boost_fail,
  input  wire logic                    ov_latched,
  input  wire logic                    input_out_of_limits,
  input  wire logic                    input_absent,
  input  wire logic                    overcurrent,
  input  wire logic                    internal_fault,
  input  wire logic                    service_request,
  input  wire logic                    comm_fault,
  input  wire logic                    output_loss_imminent,
  // control and strap pins
  input  wire logic                    on_off_n,
  input  wire logic                    interlock_n,
  input  wire logic                    slot_enable_strap_n,
  input  wire logic                    protocol_open,
  input  wire logic [STRAP_W-1:0]      unit_addr_strap,
  input  wire logic [STRAP_W-1:0]      rack_addr_strap,
  // lamps, alarms, enables
  output      als_pkg::als_lamps_t     lamps,
  output      als_pkg::als_alarm_t     alarm_oe_n,
  output      logic                    module_present,
  output      logic                    main_output_en,
  output      logic                    rs485_mode,
  output      logic [2*STRAP_W-1:0]    bus_addr
);
  import als_pkg::*;

  // ==========================================================
  // blink and pg pulse prescalers
  // ==========================================================
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;
  logic [31:0] pg_cnt_reg;
  logic        pg_pulse_reg;

  wire blink_wrap = (blink_cnt_reg == 32'(BLINK_CYC - 1));
  wire pg_wrap    = (pg_cnt_reg == 32'(PG_CYC - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_wrap ? 32'h0000_0000 : blink_cnt_reg + 32'd1;
      if (blink_wrap) begin
        blink_reg <= ~blink_reg;
      end
    end
  end

  // pg pulses: 1 ms low, 1 ms released while overloaded
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_cnt_reg   <= 32'h0000_0000;
      pg_pulse_reg <= 1'b0;
    end else begin
      pg_cnt_reg <= pg_wrap ? 32'h0000_0000 : pg_cnt_reg + 32'd1;
      if (pg_wrap) begin
        pg_pulse_reg <= ~pg_pulse_reg;
      end
    end
  end

  // ==========================================================
  // straps and mode
  // ==========================================================
  wire is_rs485   = ~protocol_open;
  wire out_permit = ~on_off_n & ~slot_enable_strap_n
                    & ~interlock_n;
  wire standby    = on_off_n & ~is_rs485;

  // ==========================================================
  // priority resolution: shutdowns above warnings
  // ==========================================================
  logic [3:0] sel;
  wire in_fail = input_fuse_blown | boost_fail | ov_latched;

  always_comb begin
    if (input_absent) begin
      sel = ALS_ST_INABSENT;
    end else if (thermal_shutdown) begin
      sel = ALS_ST_THSHUT;
    end else if (in_fail) begin
      sel = ALS_ST_INFAIL;
    end else if (input_out_of_limits) begin
      sel = ALS_ST_INLIMIT;
    end else if (standby) begin
      sel = ALS_ST_STANDBY;
    end else if (overcurrent) begin
      sel = ALS_ST_OVERCUR;
    end else if (internal_fault) begin
      sel = ALS_ST_INTFAULT;
    end else if (thermal_warn) begin
      sel = ALS_ST_THWARN;
    end else if (service_request && !is_rs485) begin
      sel = ALS_ST_SVCREQ;
    end else if (comm_fault && is_rs485) begin
      sel = ALS_ST_COMMFLT;
    end else begin
      sel = ALS_ST_OK;
    end
  end

  // ==========================================================
  // lamp and alarm mapping (1 = lamp lit / line pulled low)
  // ==========================================================
  als_lamps_t l_nx;
  logic       flt_lo;
  logic       otw_lo;
  logic       pg_lo;

  always_comb begin
    l_nx   = '{input_ok: 1'b1, output_ok: 1'b1,
               service: 1'b0, fault: 1'b0};
    flt_lo = 1'b0;
    otw_lo = 1'b0;
    pg_lo  = 1'b0;
    case (als_state_t'(sel))
      ALS_ST_THWARN: begin
        l_nx.service = 1'b1;
        otw_lo       = 1'b1;
      end
      ALS_ST_THSHUT: begin
        l_nx.service   = 1'b1;
        l_nx.output_ok = 1'b0;
        l_nx.fault     = 1'b1;
        otw_lo         = 1'b1;
        flt_lo         = 1'b1;
        pg_lo          = 1'b1;
      end
      ALS_ST_INFAIL: begin
        l_nx.output_ok = 1'b0;
        l_nx.fault     = 1'b1;
        flt_lo         = 1'b1;
        pg_lo          = 1'b1;
      end
      ALS_ST_INLIMIT: begin
        l_nx.input_ok  = blink_reg;
        l_nx.output_ok = 1'b0;
        pg_lo          = 1'b1;
      end
      ALS_ST_INABSENT: begin
        l_nx  = '0;
        pg_lo = 1'b1;
      end
      ALS_ST_OVERCUR: begin
        l_nx.output_ok = blink_reg;
        pg_lo          = pg_pulse_reg;
      end
      ALS_ST_INTFAULT: begin
        l_nx.fault = 1'b1;
        flt_lo     = 1'b1;
      end
      ALS_ST_STANDBY: begin
        l_nx.output_ok = 1'b0;
        pg_lo          = 1'b1;
      end
      ALS_ST_SVCREQ: begin
        l_nx.service = blink_reg;
      end
      ALS_ST_COMMFLT: begin
        l_nx.fault = blink_reg;
      end
      default: begin
      end
    endcase
    if (output_loss_imminent) begin
      pg_lo = 1'b1;
    end
  end

  // ==========================================================
  // output registers
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lamps          <= '0;
      alarm_oe_n     <= '1;
      module_present <= 1'b0;
      main_output_en <= 1'b0;
      rs485_mode     <= 1'b0;
      bus_addr       <= '0;
    end else begin
      lamps          <= l_nx;
      alarm_oe_n     <= '{fault_oe_n: ~flt_lo,
                          power_good_warn_oe_n: ~pg_lo,
                          overtemp_warning_oe_n: ~otw_lo};
      module_present <= 1'b0;
      main_output_en <= out_permit & ~thermal_shutdown
                        & ~in_fail & ~input_absent;
      rs485_mode     <= is_rs485;
      bus_addr       <= {unit_addr_strap, rack_addr_strap};
    end
  end

  // ==========================================================
  // events, status, mask, interrupt
  // ==========================================================
  logic [`ALS_NCOND-1:0] ev_prev_reg;
  logic [`ALS_NCOND-1:0] status_reg;
  logic [`ALS_NCOND-1:0] mask_reg;
  logic                  rd_pend_reg;

  wire [`ALS_NCOND-1:0] cond = {comm_fault, service_request,
    internal_fault, overcurrent, input_absent, input_out_of_limits,
    in_fail, thermal_shutdown, thermal_warn};
  wire [`ALS_NCOND-1:0] rise = cond & ~ev_prev_reg;

  // requests wait one cycle; the answer lands on the next edge
  wire acc      = (avs_read | avs_write) & rd_pend_reg;
  wire sel_st   = (avs_address == `ALS_OFF_STATUS);
  wire sel_mask = (avs_address == `ALS_OFF_MASK);
  wire sel_cond = (avs_address == `ALS_OFF_COND);
  wire sel_ctrl = (avs_address == `ALS_OFF_CTRL);
  wire sel_addr = (avs_address == `ALS_OFF_ADDR);
  wire rd_clr   = acc & avs_read & sel_st;

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (sel_st) begin
      rdata = 32'(status_reg);
    end else if (sel_mask) begin
      rdata = 32'(mask_reg);
    end else if (sel_cond) begin
      rdata = 32'(cond);
    end else if (sel_ctrl) begin
      rdata = {26'h0, pg_lo, flt_lo, otw_lo, out_permit, is_rs485,
               standby};
    end else if (sel_addr) begin
      rdata = 32'({unit_addr_strap, rack_addr_strap});
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_reg     <= '0;
      status_reg      <= '0;
      mask_reg        <= `ALS_MASK_RST;
      rd_pend_reg     <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      irq             <= 1'b0;
    end else begin
      ev_prev_reg <= cond;
      // clear only the bits the read returned; a new event still sets
      status_reg  <= (rd_clr ? status_reg & ~avs_readdata[`ALS_NCOND-1:0]
                             : status_reg) | rise;
      if (acc && avs_write && sel_mask) begin
        mask_reg <= avs_writedata[`ALS_NCOND-1:0];
      end
      rd_pend_reg     <= (avs_read | avs_write) & ~rd_pend_reg;
      avs_waitrequest <= ~((avs_read | avs_write) & ~rd_pend_reg);
      if ((avs_read | avs_write) && !rd_pend_reg) begin
        avs_readdata <= rdata;
      end
      irq <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_shut;
    thermal_shutdown && !input_absent;
  endsequence
  sequence s_shut_out;
    !lamps.output_ok && lamps.fault && !alarm_oe_n.fault_oe_n;
  endsequence

  a_shut_lamps: assert property (s_shut |=> s_shut_out)
    else $error("thermal shutdown indication wrong");
  a_otw_low: assert property ((sel == ALS_ST_THWARN) |=>
    !alarm_oe_n.overtemp_warning_oe_n && lamps.service)
    else $error("thermal warning indication wrong");
  a_infail_pg: assert property ((sel == ALS_ST_INFAIL) |=>
    !alarm_oe_n.power_good_warn_oe_n && lamps.input_ok
    && alarm_oe_n.overtemp_warning_oe_n)
    else $error("input failure indication wrong");
  a_absent_dark: assert property (input_absent |=>
    lamps == '0 && !alarm_oe_n.power_good_warn_oe_n)
    else $error("lamps lit with input absent");
  a_intf_pg: assert property ((sel == ALS_ST_INTFAULT)
    && !output_loss_imminent |=> alarm_oe_n.power_good_warn_oe_n
    && !alarm_oe_n.fault_oe_n)
    else $error("internal fault indication wrong");
  a_out_gate: assert property (on_off_n || interlock_n
    || slot_enable_strap_n |=> !main_output_en)
    else $error("output enabled without permission");
  a_pg_early: assert property (output_loss_imminent |=>
    !alarm_oe_n.power_good_warn_oe_n)
    else $error("pg not low on imminent loss");
  a_addr_map: assert property (1'b1 |=> bus_addr ==
    {$past(unit_addr_strap), $past(rack_addr_strap)})
    else $error("address strap mapping wrong");
  a_mode_sel: assert property (1'b1 |=> rs485_mode ==
    !$past(protocol_open))
    else $error("protocol mode wrong");
  a_module_pres: assert property (##1 !module_present)
    else $error("module present not low");
  a_blink_hold: assert property ($changed(blink_reg) |=>
    $stable(blink_reg))
    else $error("blink toggled too fast");

  // ==========================================================
  // checks: remaining indications
  // ==========================================================
  // rst_n in the antecedent keeps the edge that releases reset quiet
  a_norm_lamps: assert property (rst_n && (sel == ALS_ST_OK)
    && !output_loss_imminent |=> lamps.input_ok && lamps.output_ok
    && !lamps.service && !lamps.fault && alarm_oe_n == 3'h7)
    else $error("normal indication wrong");
  a_inlimit_dark: assert property ((sel == ALS_ST_INLIMIT) |=>
    !lamps.output_ok && !lamps.service && !lamps.fault
    && alarm_oe_n.fault_oe_n && !alarm_oe_n.power_good_warn_oe_n)
    else $error("input limit indication wrong");
  a_overcur_lines: assert property ((sel == ALS_ST_OVERCUR) |=>
    lamps.input_ok && alarm_oe_n.fault_oe_n
    && alarm_oe_n.overtemp_warning_oe_n)
    else $error("overcurrent indication wrong");
  a_pg_pulse: assert property ($changed(pg_pulse_reg) |=>
    $stable(pg_pulse_reg))
    else $error("pg pulse toggled too fast");
  a_stby_pg: assert property ((sel == ALS_ST_STANDBY) |=>
    lamps.input_ok && !lamps.output_ok
    && !alarm_oe_n.power_good_warn_oe_n)
    else $error("standby indication wrong");
  a_svc_released: assert property ((sel == ALS_ST_SVCREQ)
    && !output_loss_imminent |=> alarm_oe_n == 3'h7
    && lamps.input_ok && lamps.output_ok && !lamps.fault)
    else $error("service request indication wrong");
  a_comm_released: assert property ((sel == ALS_ST_COMMFLT)
    && !output_loss_imminent |=> alarm_oe_n == 3'h7
    && lamps.input_ok && lamps.output_ok && !lamps.service)
    else $error("comm fault indication wrong");
endmodule

// *** inc/als_consts.svh ***
`ifndef ALS_CONSTS_SVH
`define ALS_CONSTS_SVH

// avalon word offsets (word indices, not byte addresses)
`define ALS_OFF_STATUS   4'h0
`define ALS_OFF_MASK     4'h1
`define ALS_OFF_COND     4'h2
`define ALS_OFF_CTRL     4'h3
`define ALS_OFF_ADDR     4'h4

// condition bit positions in the event/status word
`define ALS_B_THWARN     0
`define ALS_B_THSHUT     1
`define ALS_B_INFAIL     2
`define ALS_B_INLIMIT    3
`define ALS_B_INABSENT   4
`define ALS_B_OVERCUR    5
`define ALS_B_INTFAULT   6
`define ALS_B_SVCREQ     7
`define ALS_B_COMMFLT    8
`define ALS_NCOND        9

// reset values
`define ALS_MASK_RST     9'h000
`define ALS_CTRL_RST     1'b0

// timing
`define ALS_CLK_HZ       25000000
`define ALS_BLINK_HZ     2
`define ALS_PG_PULSE_US  1000
`define ALS_BLINK_CYC    (`ALS_CLK_HZ / (2 * `ALS_BLINK_HZ))
`define ALS_PG_CYC       (`ALS_CLK_HZ / 1000000 * `ALS_PG_PULSE_US)

`endif

// *** inc/als_pkg.sv ***
package als_pkg;

  // lamp set
  typedef struct packed {
    logic input_ok;
    logic output_ok;
    logic service;
    logic fault;
  } als_lamps_t;

  // open-drain alarm pins (oe low = pin pulled low)
  typedef struct packed {
    logic fault_oe_n;
    logic power_good_warn_oe_n;
    logic overtemp_warning_oe_n;
  } als_alarm_t;

  typedef enum logic [3:0] {
    ALS_ST_OK       = 4'b0000,
    ALS_ST_THWARN   = 4'b0001,
    ALS_ST_THSHUT   = 4'b0010,
    ALS_ST_INFAIL   = 4'b0011,
    ALS_ST_INLIMIT  = 4'b0100,
    ALS_ST_INABSENT = 4'b0101,
    ALS_ST_OVERCUR  = 4'b0110,
    ALS_ST_INTFAULT = 4'b0111,
    ALS_ST_STANDBY  = 4'b1000,
    ALS_ST_SVCREQ   = 4'b1001,
    ALS_ST_COMMFLT  = 4'b1010
  } als_state_t;

endpackage

// *** sim/alarm_led_status_logic_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
  errors++; $display("[ERR] %s exp %0h got %0h", nm, (e), (a)); end end
module alarm_led_status_logic_tb;
  import als_pkg::*;
  // ==========================================
  // signals
  logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0]  avs_address, bus_addr;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [11:0] cnd;
  logic        on_req, strap_fit, interlock_n, protocol_open;
  logic [1:0]  unit_s, rack_s;
  als_lamps_t  lamps;
  als_alarm_t  alarm_oe_n;
  logic        module_present, main_output_en, rs485_mode;
  logic        on_off_n, slot_n, fault_pin, pg_pin, otw_pin;
  int          errors, comparisons;

  als_top #(.BLINK_CYC(4), .PG_CYC(4), .STRAP_W(2)) i_dut (
    .sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
    .thermal_warn(cnd[0]), .thermal_shutdown(cnd[1]),
    .input_fuse_blown(cnd[2]), .boost_fail(cnd[3]), .ov_latched(cnd[4]),
    .input_out_of_limits(cnd[5]), .input_absent(cnd[6]),
    .overcurrent(cnd[7]), .internal_fault(cnd[8]),
    .service_request(cnd[9]), .comm_fault(cnd[10]),
    .output_loss_imminent(cnd[11]), .on_off_n, .interlock_n,
    .slot_enable_strap_n(slot_n), .protocol_open,
    .unit_addr_strap(unit_s), .rack_addr_strap(rack_s), .lamps,
    .alarm_oe_n, .module_present, .main_output_en, .rs485_mode, .bus_addr
  );

  als_shelf_ctl i_ctl (
    .alarm_oe_n, .out_on_req(on_req), .strap_fit, .fault_pin, .pg_pin,
    .otw_pin, .on_off_n, .slot_enable_strap_n(slot_n)
  );

  // ==========================================
  // tasks
  task automatic wrap_up();
    $display("counts: %0d compared, %0d mismatched", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    n = 0;
    // waitrequest and readdata are taken as they stood at the rising edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      wrap_up();
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // blinking bits must be seen both lit and dark over the window
  task automatic look(input string nm, input logic [11:0] c,
                      input logic [3:0] l_on, l_bl,
                      input logic [2:0] p_on, p_bl);
    logic [3:0] s1, s0;
    logic [2:0] q1, q0;
    @(posedge sys_clk);
    cnd <= c;
    settle(3);
    s1 = '0;
    s0 = '0;
    q1 = '0;
    q0 = '0;
    repeat (20) begin
      @(negedge sys_clk);
      s1 |= lamps;
      s0 |= ~lamps;
      q1 |= {fault_pin, otw_pin, pg_pin};
      q0 |= ~{fault_pin, otw_pin, pg_pin};
    end
    `CHK(nm, l_on | l_bl, s1)
    `CHK(nm, ~l_on, s0)
    `CHK(nm, p_on | p_bl, q1)
    `CHK(nm, ~p_on, q0)
    `CHK("module_present", 1'b0, module_present)
    $display("test %s done", nm);
  endtask

  // ==========================================
  // clock, reset, sequence
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    errors = 0;
    comparisons = 0;
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    cnd = 12'h000;
    on_req = 1'b1;
    strap_fit = 1'b1;
    interlock_n = 1'b0;
    protocol_open = 1'b1;
    unit_s = 2'h0;
    rack_s = 2'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0000_0000, rd);
    `CHK("status_rst", 32'h0000_0000, rd)
    bus(1'b0, 4'h1, 32'h0000_0000, rd);
    `CHK("mask_rst", 32'h0000_0000, rd)
    bus(1'b1, 4'h1, 32'h0000_0001, rd);
    bus(1'b1, 4'hF, 32'h0000_01FF, rd);
    bus(1'b0, 4'h1, 32'h0000_0000, rd);
    `CHK("mask", 32'h0000_0001, rd)
    bus(1'b0, 4'hF, 32'h0000_0000, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    look("normal", 12'h000, 4'hC, 4'h0, 3'h7, 3'h0);
    `CHK("out_en", 1'b1, main_output_en)
    look("thwarn", 12'h001, 4'hE, 4'h0, 3'h5, 3'h0);
    `CHK("irq_set", 1'b1, irq)
    bus(1'b0, 4'h0, 32'h0000_0000, rd);
    `CHK("status_warn", 32'h0000_0001, rd)
    settle(3);
    `CHK("irq_clr", 1'b0, irq)
    look("thshut", 12'h003, 4'hB, 4'h0, 3'h0, 3'h0);
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b0, 4'h0, 32'h0000_0000, rd);
    `CHK("status_shut", 32'h0000_0002, rd)
    for (int i = 2; i < 5; i++) begin
      look("infail", 12'h001 << i, 4'h9, 4'h0, 3'h2, 3'h0);
    end
    look("inlimit", 12'h020, 4'h0, 4'h8, 3'h6, 3'h0);
    look("absent", 12'h042, 4'h0, 4'h0, 3'h6, 3'h0);
    look("overcur", 12'h080, 4'h8, 4'h4, 3'h6, 3'h1);
    look("intfault", 12'h100, 4'hD, 4'h0, 3'h3, 3'h0);
    look("svcreq", 12'h200, 4'hC, 4'h2, 3'h7, 3'h0);
    @(posedge sys_clk);
    cnd <= 12'h800;
    settle(3);
    `CHK("pg_imminent", 1'b0, pg_pin)
    @(posedge sys_clk);
    on_req <= 1'b0;
    look("standby", 12'h000, 4'h8, 4'h0, 3'h6, 3'h0);
    `CHK("out_en_off", 1'b0, main_output_en)
    @(posedge sys_clk);
    on_req <= 1'b1;
    interlock_n <= 1'b1;
    settle(3);
    `CHK("out_en_lock", 1'b0, main_output_en)
    @(posedge sys_clk);
    interlock_n <= 1'b0;
    strap_fit <= 1'b0;
    settle(3);
    `CHK("out_en_slot", 1'b0, main_output_en)
    @(posedge sys_clk);
    strap_fit <= 1'b1;
    settle(3);
    `CHK("out_en_back", 1'b1, main_output_en)
    `CHK("pmbus_mode", 1'b0, rs485_mode)
    @(posedge sys_clk);
    protocol_open <= 1'b0;
    look("commflt", 12'h400, 4'hC, 4'h1, 3'h7, 3'h0);
    `CHK("rs485_mode", 1'b1, rs485_mode)
    bus(1'b0, 4'h2, 32'h0000_0000, rd);
    `CHK("cond_reg", 32'h0000_0100, rd)
    bus(1'b0, 4'h3, 32'h0000_0000, rd);
    `CHK("ctrl_reg", 32'h0000_0006, rd)
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      {unit_s, rack_s} <= 4'(i);
      settle(3);
      `CHK("bus_addr", 4'(i), bus_addr)
    end
    bus(1'b0, 4'h4, 32'h0000_0000, rd);
    `CHK("addr_reg", 32'h0000_000F, rd)
    $display("test straps done");
    wrap_up();
  end
endmodule

// *** sim/als_shelf_ctl.sv ***
`timescale 1ns/1ps
// ==========================================
// shelf controller watching the alarm lines
module als_shelf_ctl (
  // alarm pins from the unit
  input  wire als_pkg::als_alarm_t alarm_oe_n,
  // controller requests
  input  wire logic                out_on_req,
  input  wire logic                strap_fit,
  // pin levels as seen by the controller
  output      logic                fault_pin,
  output      logic                pg_pin,
  output      logic                otw_pin,
  // control and strap pins to the unit
  output      logic                on_off_n,
  output      logic                slot_enable_strap_n
);
  import als_pkg::*;
  // pull-ups: a released line reads high, never the last driven level
  assign fault_pin = alarm_oe_n.fault_oe_n ? 1'b1 : 1'b0;
  assign pg_pin = alarm_oe_n.power_good_warn_oe_n ? 1'b1 : 1'b0;
  assign otw_pin = alarm_oe_n.overtemp_warning_oe_n ? 1'b1 : 1'b0;
  // output on means on/off shorted to logic_ground
  assign on_off_n = ~out_on_req;
  // fitted strap is the low-resistance path
  assign slot_enable_strap_n = ~strap_fit;
endmodule
